// ### verification/mmvr_core_model.sv
// Core model issuing byte reads and writes
`timescale 1ns/10ps
module mmvr_core_model (
  // Clock
  input  wire         mclk,
  // Request
  output logic [15:0] bus_addr,
  output logic        bus_rd,
  output logic        bus_wr,
  output logic [7:0]  bus_wdata,
  // Answer
  input  wire [7:0]   bus_rdata_q,
  input  wire         bus_hit_q
);
  initial begin
    bus_addr = 16'h0000;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 8'h00;
  end
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d,
           output logic [7:0] r, output logic h);
    @(posedge mclk);
    bus_rd <= !w;
    bus_wr <= w;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge mclk);
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
    // Released lines move so a stale value never passes for data
    bus_addr <= ~a;
    bus_wdata <= ~d;
    #1;
    h = bus_hit_q;
    // Data lags the hit by one cycle: array and output stage are both registered
    @(posedge mclk);
    #1;
    r = bus_rdata_q;
  endtask
endmodule

// ### verification/mmvr_decode_checker.sv
// Port assertions for the memory map decoder
`timescale 1ns/10ps
module mmvr_decode_checker (
  // Clock and reset
  input wire        mclk,
  input wire        reset,
  // Core bus
  input wire [15:0] bus_addr,
  input wire        bus_rd,
  input wire        bus_wr,
  input wire        bus_hit_q,
  // Stack
  input wire        sp_reset_instr,
  input wire        sp_load,
  input wire        push,
  input wire        pull,
  input wire        call_entry,
  input wire        int_entry,
  input wire [15:0] stack_pointer_q,
  input wire [2:0]  stack_bytes_q,
  // Vectors and watchdog
  input wire        int_accept,
  input wire        vector_valid_q,
  input wire        watchdog_clear_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Higher priority stack requests mask the frame ones
  wire hold = sp_reset_instr | sp_load;
  a_sp_home: assert property (sp_reset_instr |=> stack_pointer_q == 16'h00FF)
    else $error("stack pointer not home");
  a_int_five: assert property (int_entry && !hold |=> stack_bytes_q == 3'h5)
    else $error("interrupt frame size");
  a_call_two: assert property (call_entry && !int_entry && !hold |=> stack_bytes_q == 3'h2)
    else $error("call frame size");
  a_push_down: assert property (push && !pull && !call_entry && !int_entry && !hold
    |=> stack_pointer_q == $past(stack_pointer_q) - 16'h0001) else $error("push step");
  a_wdog_clear: assert property (bus_wr && bus_addr == 16'hFFFF |=> watchdog_clear_q)
    else $error("watchdog not cleared");
  a_wdog_cause: assert property (watchdog_clear_q |-> $past(bus_wr) && $past(bus_addr) == 16'hFFFF)
    else $error("stray watchdog clear");
  a_ram_hit: assert property ((bus_rd || bus_wr) && bus_addr >= 16'h0A00 && bus_addr <= 16'h0DFF
    |=> bus_hit_q) else $error("upper RAM missed");
  a_vec_three: assert property (vector_valid_q |-> $past(int_accept, 3))
    else $error("vector timing");
endmodule
bind mmvr_decode mmvr_decode_checker i_chk (.*);

// ### verification/mmvr_decode_tb.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module mmvr_decode_tb;
  reg         mclk = 1'b0, reset = 1'b1, sp_reset_instr = 1'b0, sp_load = 1'b0;
  reg         push = 1'b0, pull = 1'b0, call_entry = 1'b0, int_entry = 1'b0;
  reg         int_accept = 1'b0, vec_wr = 1'b0, hit;
  reg  [15:0] sp_load_val = 16'h0000;
  reg  [25:0] int_pending = 26'h0000000;
  reg  [5:0]  vec_waddr = 6'h00;
  reg  [7:0]  vec_wdata = 8'h00, rd;
  reg  [15:0] ta [0:7] = '{16'h0050, 16'h00FF, 16'h044F, 16'h0A00, 16'h0DFF,
                           16'h0450, 16'h004F, 16'h0E00};
  wire [15:0] bus_addr, stack_pointer_q, vector_q;
  wire [7:0]  bus_wdata, bus_rdata_q;
  wire [2:0]  stack_bytes_q;
  wire [4:0]  vector_src_q;
  wire        bus_rd, bus_wr, bus_hit_q, vector_valid_q, watchdog_clear_q;
  int         bad_count = 0, tests_run = 0, cyc = 0, i, wd_n = 0;
  mmvr_decode i_dut (.*);
  mmvr_core_model i_core (.*);
  function [7:0] vb(input [5:0] k);
    vb = {2'h0, k} ^ 8'hA5;
  endfunction
  task stk(input [5:0] k, input [15:0] sp, input [2:0] nb);
    @(posedge mclk);
    {sp_reset_instr, sp_load, int_entry, call_entry, push, pull} <= k;
    sp_load_val <= 16'h0DFF;
    @(posedge mclk);
    {sp_reset_instr, sp_load, int_entry, call_entry, push, pull} <= 6'h00;
    #1;
    `CHK(stack_pointer_q, sp)
    `CHK(stack_bytes_q, nb)
  endtask
  task vec(input [25:0] p, input [4:0] s);
    @(posedge mclk);
    int_pending <= p;
    int_accept <= 1'b1;
    @(posedge mclk);
    int_accept <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    `CHK(vector_valid_q, 1'b1)
    `CHK(vector_src_q, s)
    `CHK(vector_q, {vb({s, 1'b0}), vb({s, 1'b1})})
  endtask
  task t_stack;
    `CHK(stack_pointer_q, 16'h00FF)
    stk(6'h08, 16'h00FA, 3'h5);
    stk(6'h04, 16'h00F8, 3'h2);
    stk(6'h02, 16'h00F7, 3'h0);
    stk(6'h01, 16'h00F8, 3'h0);
    stk(6'h03, 16'h00F8, 3'h0);
    stk(6'h10, 16'h0DFF, 3'h0);
    stk(6'h20, 16'h00FF, 3'h0);
  endtask
  task t_bus;
    for (i = 0; i < 8; i++) begin
      i_core.acc(1'b1, ta[i], ta[i][7:0] ^ 8'h5A, rd, hit);
      `CHK(hit, i < 5)
    end
    for (i = 0; i < 5; i++) begin
      i_core.acc(1'b0, ta[i], 8'h00, rd, hit);
      `CHK(rd, ta[i][7:0] ^ 8'h5A)
    end
  endtask
  task t_wdog;
    int n0;
    n0 = wd_n;
    i_core.acc(1'b1, 16'hFFFF, 8'h00, rd, hit);
    `CHK(wd_n, n0 + 1)
    `CHK(hit, 1'b1)
    i_core.acc(1'b1, 16'hFFFE, 8'h00, rd, hit);
    i_core.acc(1'b0, 16'hFFFE, 8'h00, rd, hit);
    `CHK(rd, vb(6'h32))
    i_core.acc(1'b0, 16'hFFFF, 8'h00, rd, hit);
    `CHK(rd, vb(6'h33))
    `CHK(wd_n, n0 + 1)
  endtask
  task end_of_test;
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    forever #4 mclk = ~mclk;
  end
  // Watchdog pulse stands one cycle only, so count it as it passes
  always @(posedge mclk) begin
    if (watchdog_clear_q === 1'b1) begin
      wd_n <= wd_n + 1;
    end
  end
  // Whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      end_of_test;
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    for (i = 0; i < 52; i++) begin
      @(posedge mclk);
      vec_wr <= 1'b1;
      vec_waddr <= i[5:0];
      vec_wdata <= vb(i[5:0]);
    end
    @(posedge mclk);
    vec_wr <= 1'b0;
    t_stack;
    t_bus;
    t_wdog;
    vec(26'h3FFFFFF, 5'h19);
    vec(26'h0000401, 5'h0A);
    vec(26'h1800000, 5'h18);
    vec(26'h0000001, 5'h00);
    end_of_test;
  end
endmodule

// ### verilog/mmvr_decode.v
// Memory map decoder: RAM, vector table, watchdog clear and core stack model
// Overview of operation
// - 2048 RAM bytes decoded at 0x0050-0x044F and 0x0A00-0x0DFF.
// - Direct page holds 176 RAM bytes, 0x0050 to 0x00FF.
// - Stack pointer is 16 bits; reset-instruction returns it to its reset location.
// - Stack pointer holds 0x00FF after reset.
// - Interrupt entry pushes five register bytes.
// - High index byte is not stacked on interrupt entry.
// - Subroutine call pushes exactly two return-address bytes.
// - Push decrements stack pointer, pull increments it.
// - Two-byte vectors, high byte even, table 0xFFCC to 0xFFFF.
// - Priority rises with vector address; reset highest.
// - Read 0xFFFF gives reset vector low; write clears watchdog.
// - Peripheral vectors sit at their fixed pairs, CAN wakeup at 0xFFE0.
`timescale 1ns/10ps
`include "mmvr_defs.vh"
module mmvr_decode #(
  parameter NSRC = 26
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             reset,
  // Core bus
  input  wire [15:0]      bus_addr,
  input  wire             bus_rd,
  input  wire             bus_wr,
  input  wire [7:0]       bus_wdata,
  output reg  [7:0]       bus_rdata_q,
  output reg              bus_hit_q,
  // Core stack operations
  input  wire             sp_reset_instr,
  input  wire             sp_load,
  input  wire [15:0]      sp_load_val,
  input  wire             push,
  input  wire             pull,
  input  wire             call_entry,
  input  wire             int_entry,
  output reg  [15:0]      stack_pointer_q,
  output reg  [2:0]       stack_bytes_q,
  // Interrupt sources, bit 0 lowest priority, bit 25 reset
  input  wire [NSRC-1:0]  int_pending,
  input  wire             int_accept,
  output reg  [15:0]      vector_q,
  output reg              vector_valid_q,
  output reg  [4:0]       vector_src_q,
  // Vector store written by the flash programmer side
  input  wire             vec_wr,
  input  wire [5:0]       vec_waddr,
  input  wire [7:0]       vec_wdata,
  // Watchdog
  output reg              watchdog_clear_q
);
  localparam ST_IDLE = 2'b00;
  localparam ST_HIGH = 2'b01;
  localparam ST_LOW  = 2'b10;

  reg  [7:0]  vec_mem [0:2*NSRC-1];
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [4:0]  src_d;
  reg         any_d;
  reg  [15:0] ram_idx;
  reg  [15:0] sp_d;
  reg  [2:0]  bytes_d;
  reg  [7:0]  rd_mux;
  reg         rd_vec_q;
  reg  [7:0]  rd_vec_byte_q;
  integer     i;

  wire        in_ram1 = (bus_addr >= `MMVR_RAM1_LO) && (bus_addr <= `MMVR_RAM1_HI);
  wire        in_ram2 = (bus_addr >= `MMVR_RAM2_LO) && (bus_addr <= `MMVR_RAM2_HI);
  wire        in_vec  = (bus_addr >= `MMVR_VEC_LO);
  wire [15:0] vec_off = bus_addr - `MMVR_VEC_LO;
  wire [5:0]  vec_idx = vec_off[5:0];
  wire [7:0]  ram_rdata;
  wire        ram_we  = bus_wr && (in_ram1 || in_ram2);

  always @* begin
    if (in_ram1) begin
      ram_idx = bus_addr - `MMVR_RAM1_LO;
    end else begin
      ram_idx = bus_addr - `MMVR_RAM2_LO + {4'h0, `MMVR_RAM1_SIZE};
    end
  end

  // direct page part is indices 0..175 of the same array
  mmvr_ram #(
    .AW    (11),
    .DEPTH (2048)
  ) u_ram (
    .mclk  (mclk),
    .we    (ram_we),
    .addr  (ram_idx[10:0]),
    .wdata (bus_wdata),
    .rdata (ram_rdata)
  );

  // vector pairs stored high byte at even address
  always @(posedge mclk) begin
    if (vec_wr) begin
      vec_mem[vec_waddr] <= vec_wdata;
    end
    rd_vec_byte_q <= vec_mem[vec_idx];
  end

  always @* begin
    if (rd_vec_q) begin
      rd_mux = rd_vec_byte_q;
    end else begin
      rd_mux = ram_rdata;
    end
  end

  // Output stage follows the registered arrays: data two cycles after request, hit after one
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_vec_q    <= 1'b0;
      bus_hit_q   <= 1'b0;
      bus_rdata_q <= 8'h00;
    end else begin
      rd_vec_q    <= in_vec;
      bus_hit_q   <= (bus_rd || bus_wr) && (in_ram1 || in_ram2 || in_vec);
      bus_rdata_q <= rd_mux;
    end
  end

  // write to top byte clears watchdog, never stores
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      watchdog_clear_q <= 1'b0;
    end else begin
      watchdog_clear_q <= bus_wr && (bus_addr == `MMVR_VEC_WDOG);
    end
  end

  always @* begin
    sp_d    = stack_pointer_q;
    bytes_d = 3'h0;
    if (sp_reset_instr) begin
      sp_d = `MMVR_SP_RESET;
    end else if (sp_load) begin
      sp_d = sp_load_val;
    end else if (int_entry) begin
      // Index high byte left out to keep the older five-byte frame
      sp_d    = stack_pointer_q - {13'h0, `MMVR_INT_BYTES};
      bytes_d = `MMVR_INT_BYTES;
    end else if (call_entry) begin
      sp_d    = stack_pointer_q - {13'h0, `MMVR_CALL_BYTES};
      bytes_d = `MMVR_CALL_BYTES;
    end else if (push && !pull) begin
      sp_d = stack_pointer_q - 16'h0001;
    end else if (pull && !push) begin
      sp_d = stack_pointer_q + 16'h0001;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      stack_pointer_q <= `MMVR_SP_RESET;
      stack_bytes_q   <= 3'h0;
    end else begin
      stack_pointer_q <= sp_d;
      stack_bytes_q   <= bytes_d;
    end
  end

  always @* begin
    src_d = 5'h00;
    any_d = 1'b0;
    for (i = 0; i < NSRC; i = i + 1) begin
      if (int_pending[i]) begin
        src_d = i[4:0];
        any_d = 1'b1;
      end
    end
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (int_accept && any_d) begin
          state_d = ST_HIGH;
        end
      end
      ST_HIGH: state_d = ST_LOW;
      ST_LOW:  state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // source index maps to fixed pair address
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q        <= ST_IDLE;
      vector_src_q   <= 5'h00;
      vector_q       <= 16'h0000;
      vector_valid_q <= 1'b0;
    end else begin
      state_q        <= state_d;
      vector_valid_q <= 1'b0;
      if (state_q == ST_IDLE && state_d == ST_HIGH) begin
        vector_src_q <= src_d;
      end
      if (state_q == ST_HIGH) begin
        vector_q[15:8] <= vec_mem[{vector_src_q, 1'b0}];
      end
      if (state_q == ST_LOW) begin
        vector_q[7:0]  <= vec_mem[{vector_src_q, 1'b1}];
        vector_valid_q <= 1'b1;
      end
    end
  end
endmodule

// ### verilog/mmvr_defs.vh
// Address map, vector table and stack constants for the memory map decoder
`ifndef MMVR_DEFS_VH
`define MMVR_DEFS_VH
`define MMVR_RAM1_LO     16'h0050
`define MMVR_RAM1_HI     16'h044F
`define MMVR_RAM2_LO     16'h0A00
`define MMVR_RAM2_HI     16'h0DFF
`define MMVR_RAM1_SIZE   12'h400
`define MMVR_PAGE0_TOP   16'h00FF
`define MMVR_SP_RESET    16'h00FF
`define MMVR_VEC_LO      16'hFFCC
`define MMVR_VEC_WDOG    16'hFFFF
`define MMVR_VEC_WORDS   6'h1A
`define MMVR_VEC_BASE_W  15'h7FE6
`define MMVR_SRC_SWI     5'h18
`define MMVR_SRC_RESET   5'h19
`define MMVR_INT_BYTES   3'h5
`define MMVR_CALL_BYTES  3'h2
`endif

// ### verilog/mmvr_ram.v
// Byte-wide RAM array with one access port: write and registered read share one address
`timescale 1ns/10ps
module mmvr_ram #(
  parameter AW = 11,
  parameter DEPTH = 2048
) (
  // Clock
  input  wire          mclk,
  // Access port
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [7:0]    wdata,
  output reg  [7:0]    rdata
);
  reg [7:0] mem [0:DEPTH-1];

  // No reset on the array; contents are undefined until written
  always @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
